// file: src/dacfe_pkg.sv
`default_nettype none
package dacfe_pkg;
   localparam int SAMPLE_W   = 14;
   localparam int LADDER_W   = 10;
   localparam int SEG_IN_W   = 4;
   localparam int SEG_W      = 15;
   localparam int BUF_DEPTH  = 2;
   localparam int SYNC_DEPTH = 3;
   localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 14'h0000;
   localparam logic [SAMPLE_W-1:0] MIDSCALE     = 14'h2000;

   typedef struct packed {
      logic [SEG_W-1:0]    seg_en;
      logic [LADDER_W-1:0] ladder;
   } dacfe_drive_t;
endpackage : dacfe_pkg
`default_nettype wire

// file: src/dacfe_top.sv
`timescale 1ns/10ps
`default_nettype none
module dacfe_top
(
   input  wire logic                          clk_sys_i,
   input  wire logic                          reset_i,
   input  wire logic [dacfe_pkg::SAMPLE_W-1:0] sample_word_bits_i,
   input  wire logic                          sample_valid_i,
   output logic                               sample_ready_o,
   output dacfe_pkg::dacfe_drive_t            drive_o,
   output logic [dacfe_pkg::SAMPLE_W-1:0]     sample_hold_o,
   output logic                               drive_valid_o,
   input  wire logic                          drive_ready_i
);
   import dacfe_pkg::*;

   // ----------------------------------------------------------------
   // thermometer decode
   // ----------------------------------------------------------------
   function automatic logic [SEG_W-1:0] therm(input logic [SEG_IN_W-1:0] v);
      logic [SEG_W-1:0] r;
      r = '0;
      for (int i = 0; i < SEG_W; i++)
      begin
         r[i] = (SEG_IN_W'(i) < v);
      end
      return r;
   endfunction : therm

   // word present in the buffer; shared by hold select and valid
   function automatic logic occupied(input logic [1:0] fill);
      return fill != 2'h0;
   endfunction : occupied

   // ----------------------------------------------------------------
   // two-entry skid buffer; ready stays high while one slot is free
   // ----------------------------------------------------------------
   logic [SAMPLE_W-1:0] mem_q [BUF_DEPTH];
   logic [SAMPLE_W-1:0] mem_d [BUF_DEPTH];
   // two slots let upstream push one more word into a consumer stall before ready drops
   logic [1:0]          cnt_q;
   logic [1:0]          cnt_d;
   logic                rd_q;
   logic                rd_d;
   logic                wr_q;
   logic                wr_d;
   logic                push;
   logic                pop;

   assign push = sample_valid_i && sample_ready_o;
   assign pop  = drive_valid_o && drive_ready_i;

   always_comb
   begin
      mem_d = mem_q;
      cnt_d = cnt_q;
      rd_d  = rd_q;
      wr_d  = wr_q;
      // write slot meets read slot only when empty or full; full drops ready
      if (push)
      begin
         mem_d[wr_q] = sample_word_bits_i;
         wr_d        = ~wr_q;
      end
      if (pop)
      begin
         rd_d = ~rd_q;
      end
      cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         mem_q <= '{default: SAMPLE_RESET};
         cnt_q <= 2'h0;
         rd_q  <= 1'b0;
         wr_q  <= 1'b0;
      end
      else
      begin
         mem_q <= mem_d;
         cnt_q <= cnt_d;
         rd_q  <= rd_d;
         wr_q  <= wr_d;
      end
   end

   // ----------------------------------------------------------------
   // holding register and drive outputs
   // ----------------------------------------------------------------
   logic [SAMPLE_W-1:0] hold_d;
   dacfe_drive_t        drv_d;
   logic                vld_d;
   logic                rdy_d;

   always_comb
   begin
      hold_d = sample_hold_o;
      // whole word updates when the consumer takes it and another waits, or a word enters the empty buffer, never partially
      if (occupied(cnt_d))
      begin
         hold_d = mem_d[rd_d];
      end
      vld_d        = occupied(cnt_d);
      rdy_d        = (cnt_d < 2'(BUF_DEPTH));
      drv_d.ladder = hold_d[LADDER_W-1:0];
      // straight binary: code value n lights n segments, so all ones is full scale
      drv_d.seg_en = therm(hold_d[SAMPLE_W-1:LADDER_W]);
   end

   // ----------------------------------------------------------------
   // output registers; every port leaves straight from a flop
   // ----------------------------------------------------------------

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         sample_hold_o  <= SAMPLE_RESET;
         drive_o        <= '0;
         drive_valid_o  <= 1'b0;
         sample_ready_o <= 1'b1;
      end
      else
      begin
         sample_hold_o  <= hold_d;
         drive_o        <= drv_d;
         drive_valid_o  <= vld_d;
         sample_ready_o <= rdy_d;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_push;
      sample_valid_i && sample_ready_o && cnt_q == 2'h0;
   endsequence

   AST_EMPTY_PUSH_SHOWS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_push |=> drive_valid_o && sample_hold_o == $past(sample_word_bits_i))
      else $error("word not shown after push into empty buffer");

   // ----------------------------------------------------------------
   // decode checks
   // ----------------------------------------------------------------
   AST_LADDER: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      drive_o.ladder == sample_hold_o[LADDER_W-1:0])
      else $error("ladder bits differ from held word");
   AST_SEG_COUNT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $countones(drive_o.seg_en) == int'(sample_hold_o[SAMPLE_W-1:LADDER_W]))
      else $error("segment count wrong");
   AST_SEG_ORDER: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ((drive_o.seg_en + 15'h0001) & drive_o.seg_en) == 15'h0000)
      else $error("segments not filled from lowest");
   AST_FULL_SCALE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      sample_hold_o == 14'h3fff |-> drive_o.seg_en == 15'h7fff && &drive_o.ladder)
      else $error("full scale drive wrong");
   AST_MIDSCALE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      sample_hold_o == MIDSCALE |-> drive_o.seg_en == 15'h00ff && drive_o.ladder == 10'h000)
      else $error("midscale drive wrong");
   AST_ZERO_SCALE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      sample_hold_o == 14'h0000 |-> drive_o == '0)
      else $error("zero code drives current");
   // top cell and bottom ladder bit pin the word's orientation
   AST_BIT_ORDER: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_push |=> drive_o.seg_en[SEG_W-1] == $past(&sample_word_bits_i[SAMPLE_W-1:LADDER_W])
         && drive_o.ladder[0] == $past(sample_word_bits_i[0]))
      else $error("sample bits not in msb to lsb order");

   // ----------------------------------------------------------------
   // buffer checks
   // ----------------------------------------------------------------
   AST_HOLD_STABLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      drive_valid_o && !drive_ready_i |=> $stable(sample_hold_o))
      else $error("held word changed while stalled");
   AST_FULL_STALL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      cnt_q == 2'h2 |-> !sample_ready_o)
      else $error("ready high while buffer full");
   AST_ROOM_READY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      cnt_q < 2'h2 |-> sample_ready_o)
      else $error("ready low while a slot is free");
   AST_VALID_COUNT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      drive_valid_o == (cnt_q != 2'h0))
      else $error("valid disagrees with buffer fill");
   AST_NO_OVERFILL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      cnt_q != 2'h3)
      else $error("buffer fill out of range");

   sequence s_take;
      drive_valid_o && drive_ready_i;
   endsequence

   sequence s_quiet;
      !(drive_valid_o && drive_ready_i) && !(sample_valid_i && sample_ready_o);
   endsequence

   // two pushes with the consumer stalled fill both slots
   sequence s_fill;
      s_push ##1 (sample_valid_i && sample_ready_o && !drive_ready_i);
   endsequence

   AST_QUIET_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_quiet |=> $stable(sample_hold_o) && $stable(drive_o))
      else $error("held word changed with no transfer");
   AST_LAST_TAKE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_take ##0 (cnt_q == 2'h1 && !push) |=> !drive_valid_o && $stable(sample_hold_o))
      else $error("last word taken but valid stayed");
   AST_NEXT_SHOWN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_take ##0 (cnt_q == 2'h2) |=> drive_valid_o && sample_ready_o)
      else $error("second word not shown after take");
   AST_FILL_STALLS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      s_fill |=> !sample_ready_o && drive_valid_o)
      else $error("buffer did not stall when full");

   // ----------------------------------------------------------------
   // reset checks
   // ----------------------------------------------------------------
   AST_RESET_STATE: assert property (@(posedge clk_sys_i)
      reset_i |=> !drive_valid_o && sample_ready_o && sample_hold_o == SAMPLE_RESET
         && drive_o == '0)
      else $error("outputs not at rest after reset");
endmodule : dacfe_top
`default_nettype wire

// file: tb/dacfe_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module dacfe_src_model
(
   input  wire logic                          clk_sys_i,
   input  wire logic                          push_i,
   input  wire logic [dacfe_pkg::SAMPLE_W-1:0] push_word_i,
   input  wire logic                          sample_ready_i,
   output logic                               sample_valid_o,
   output logic [dacfe_pkg::SAMPLE_W-1:0]     sample_word_bits_o
);
   import dacfe_pkg::*;
   logic [SAMPLE_W-1:0] q[$];
   initial sample_valid_o = 1'b0;
   initial sample_word_bits_o = '0;
   // idle data toggles so a stale word is never mistaken for a new one
   always @(posedge clk_sys_i)
   begin
      if (sample_valid_o && sample_ready_i)
         void'(q.pop_front());
      if (push_i)
         q.push_back(push_word_i);
      sample_valid_o <= q.size() != 0;
      sample_word_bits_o <= q.size() != 0 ? q[0] : ~sample_word_bits_o;
   end
endmodule : dacfe_src_model
`default_nettype wire

// file: tb/test_dacfe_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_dacfe_top;
   import dacfe_pkg::*;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, push = 1'b0, rdy = 1'b0, s_vld, s_rdy, d_vld;
   logic [SAMPLE_W-1:0] pw = '0, s_w, hold, exp_q[$];
   logic [SAMPLE_W-1:0] codes[6] = '{14'h0000, 14'h3fff, MIDSCALE, 14'h03ff, 14'h0400, 14'h1c00};
   dacfe_drive_t drv;
   int fail_count = 0, cmp_count = 0;
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   dacfe_src_model SRC (.clk_sys_i, .push_i(push), .push_word_i(pw), .sample_ready_i(s_rdy),
      .sample_valid_o(s_vld), .sample_word_bits_o(s_w));
   dacfe_top DUT (.clk_sys_i, .reset_i, .sample_word_bits_i(s_w), .sample_valid_i(s_vld),
      .sample_ready_o(s_rdy), .drive_o(drv), .sample_hold_o(hold), .drive_valid_o(d_vld),
      .drive_ready_i(rdy));
   task automatic fail(input string m);
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail
   task automatic cmp_bit(input logic g, input logic e);
      cmp_count++;
      if (g !== e) fail("flag mismatch");
   endtask : cmp_bit
   task automatic cmp_out(input logic [SAMPLE_W-1:0] w);
      cmp_count++;
      if (hold !== w || drv !== {15'((16'h1 << w[13:10]) - 16'h1), w[9:0]})
         fail("output mismatch");
   endtask : cmp_out
   // words are judged in arrival order at the edge the consumer takes them
   always @(posedge clk_sys_i)
      if (d_vld && rdy && exp_q.size() != 0)
         cmp_out(exp_q.pop_front());
   task automatic send(input logic [SAMPLE_W-1:0] w);
      @(posedge clk_sys_i);
      push <= 1'b1;
      pw <= w;
      exp_q.push_back(w);
   endtask : send
   task automatic stop();
      @(posedge clk_sys_i);
      push <= 1'b0;
   endtask : stop
   task automatic drain(input string n);
      for (int i = 0; i < 100 && exp_q.size() != 0; i++)
         @(posedge clk_sys_i);
      if (exp_q.size() != 0)
      begin
         fail("drain timeout");
         tally_and_finish();
      end
      else
      begin
         $display("%s done", n);
      end
   endtask : drain
   task automatic test_codes();
      rdy <= 1'b1;
      foreach (codes[i]) send(codes[i]);
      stop();
      drain("codes");
   endtask : test_codes
   task automatic test_stall();
      rdy <= 1'b0;
      for (int i = 0; i < 5; i++) send(14'h2aa5 ^ 14'(i * 1029));
      stop();
      repeat (8) @(posedge clk_sys_i);
      cmp_bit(s_rdy, 1'b0);
      cmp_bit(d_vld, 1'b1);
      rdy <= 1'b1;
      drain("stall");
   endtask : test_stall
   task automatic test_reset();
      rdy <= 1'b0;
      send(14'h1234);
      send(14'h0abc);
      stop();
      repeat (4) @(posedge clk_sys_i);
      cmp_bit(s_rdy, 1'b0);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      exp_q.delete();
      @(posedge clk_sys_i);
      cmp_bit(s_rdy, 1'b1);
      cmp_bit(d_vld, 1'b0);
      cmp_out(14'h0000);
      rdy <= 1'b1;
      send(14'h3c01);
      stop();
      drain("reset");
   endtask : test_reset
   task automatic tally_and_finish();
      $display("compares %0d fails %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      cmp_bit(s_rdy, 1'b1);
      cmp_bit(d_vld, 1'b0);
      test_codes();
      test_stall();
      test_reset();
      tally_and_finish();
   end
endmodule : test_dacfe_top
`default_nettype wire
